// ==== sbc_defs.svh ====
/*
 * sbc_defs.svh - register offsets, field positions, reset values and timing counts
 * for the system basis chip serial register interface.
 * assumes: included by bare name from the register interface design file.
 */
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH

// ---------------------------------------------------------------
// register addresses (4-bit frame address)
// ---------------------------------------------------------------
`define SBC_ADR_MODE        4'h0
`define SBC_ADR_VMON        4'h1
`define SBC_ADR_WAKE_CTL    4'h2
`define SBC_ADR_WAKE_STS    4'h3
`define SBC_ADR_LIN_CTL     4'h4
`define SBC_ADR_LIN_STS     4'h5
`define SBC_ADR_HS_CTL      4'h6
`define SBC_ADR_HS_STS      4'h7
`define SBC_ADR_LS_CTL      4'h8
`define SBC_ADR_LS_STS      4'h9
`define SBC_ADR_TIM_CTL     4'hA
`define SBC_ADR_WD_STS      4'hB
`define SBC_ADR_AMUX_CTL    4'hC
`define SBC_ADR_CFG         4'hD
`define SBC_ADR_IRQ_MASK    4'hE
`define SBC_ADR_IRQ_SRC     4'hF

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SBC_MODE_OVSD_BIT   3
`define SBC_LIN_RECEIVE_ONLY_BIT_BIT  2
`define SBC_LINSTS_SHORT    3
`define SBC_LINSTS_TXD_STUCK_FLAG    2
`define SBC_LINSTS_OTEMP    1
`define SBC_IMR_LIN_BIT     1
`define SBC_ISR_LIN_WAKE    4'h1
`define SBC_ISR_LIN_FAULT   4'h2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SBC_MODE_RST        4'h8
`define SBC_LIN_CTL_RST     4'h0
`define SBC_IMR_RST         4'h0
`define SBC_WAKE_CTL_RST    4'hF

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SBC_CLK_HZ          25000000
`define SBC_TXD_STUCK_MS    1000
`define SBC_TXD_STUCK_CYC   ((`SBC_CLK_HZ / 1000) * `SBC_TXD_STUCK_MS)
`define SBC_WAKE_FILT_US    150
`define SBC_WAKE_FILT_CYC   ((`SBC_CLK_HZ / 1000000) * `SBC_WAKE_FILT_US)
`define SBC_FRAME_BITS      8

`endif

// ==== sbc_pkg.sv ====
/*
 * sbc_pkg.sv - types shared by the register interface.
 * assumes: nothing beyond the defs header.
 */
package sbc_pkg;
	// operating mode as decoded from the two mode select bits
	typedef enum logic [1:0] {
		SBC_MODE_NORMAL,
		SBC_MODE_STOP,
		SBC_MODE_SLEEP,
		SBC_MODE_NORMAL_WDCLR
	} sbc_mode_e;

	// wake filter progress
	typedef enum logic [1:0] {
		SBC_WK_IDLE,
		SBC_WK_DOM,
		SBC_WK_ARMED
	} sbc_wake_e;
endpackage : sbc_pkg

// ==== sbc_sync.sv ====
/*
 * sbc_sync.sv - two flip-flop synchroniser, one per bit.
 * assumes: inputs asynchronous to clk_sys; reset value given by parameter.
 */
`timescale 1ns/1ps
`default_nettype none
module sbc_sync #(
	parameter int         WIDTH = 4,
	parameter logic [3:0] INIT  = 4'hF
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] held;
	} sbc_sync_s;

	sbc_sync_s st_ff;
	sbc_sync_s nxt_st;

	// first stage only feeds the second
	always_comb begin
		nxt_st.meta = async_in;
		nxt_st.held = st_ff.meta;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_ff <= {INIT[WIDTH-1:0], INIT[WIDTH-1:0]};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sync_out = st_ff.held;
endmodule : sbc_sync
`default_nettype wire

// ==== sbc_spi_regs.sv ====
/*
 * sbc_spi_regs.sv - serial slave register interface with LIN status logic.
 * assumes: host is SPI master; pins asynchronous to clk_sys and sampled here.
 */
// Function
// - TXD low over one second shuts transmitter and sets txd_stuck_flag.
// - lin_irq_mask set makes a stuck-TXD fault assert the interrupt.
// - transmitter re-enables by itself once TXD returns high.
// - status read with TXD high clears txd_stuck_flag; TXD low keeps it.
// - receive_only_bit in normal mode disables transmitter, receiver stays.
// - any LIN error sets receive_only_bit automatically.
// - stop mode with receive_only_bit disables LIN wake; RXD follows bus.
// - stop mode: long dominant then rising edge sets LIN wake as interrupt source.
// - sleep mode: long dominant then rising edge requests wake-up reset.
// - one byte frame: address and control in, summary and status out.
// - chip select fall enables MISO and captures returned status.
// - outputs change on SCLK rise, inputs sampled on SCLK fall.
// - frame valid only with exactly eight sampling edges.
// - chip select rise commits write; MISO tri-stated while deselected.
// - power-on, reset mode or pin reset restore bits; POR sets power_loss_flag.
// - even addresses return paired status, except C which reads zero; only mode, LIN control and interrupt mask take writes; odd read only.
// - summary nibble leads every frame regardless of address.
// - voltage_summary_flag is OR of voltage monitor bits.
// - lin_summary_flag is OR of LIN status bits.
// - high and low side summary flags are OR of their fault bits.
// - mode write returns voltage monitor; shutdown enable resets to one.
// - overvoltage with shutdown enabled switches off both side drivers.
// - mode bits decode normal, stop, sleep, normal with watchdog clear.
// - any access to mode or voltage monitor clears power_loss_flag.
// - status read without RXD short clears rx_pin_short_flag.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.svh"
module sbc_spi_regs
	import sbc_pkg::*;
#(
	parameter int TXD_STUCK_CYC = `SBC_TXD_STUCK_CYC,
	parameter int WAKE_FILT_CYC = `SBC_WAKE_FILT_CYC
) (
	// clock and resets
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       por_pulse,
	input  wire logic       reset_mode,
	input  wire logic       pin_reset,
	// serial pins
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic       mosi,
	output logic            miso_o,
	output logic            miso_oe,
	// LIN transceiver side
	input  wire logic       txd,
	input  wire logic       lin_rx,
	input  wire logic       lin_overtemp,
	input  wire logic       rxd_short,
	output logic            lin_tx_enable,
	output logic            rxd_follow_bus,
	// analog status inputs
	input  wire logic [3:0] vmon_status,
	input  wire logic [3:0] wake_status,
	input  wire logic [3:0] hs_status,
	input  wire logic [3:0] ls_status,
	input  wire logic [3:0] wd_status,
	// outputs to the rest of the chip
	output logic            irq_n,
	output logic            side_drivers_off,
	output logic [1:0]      op_mode,
	output logic            watchdog_clear,
	output logic            wake_reset_req
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic             cs_q;
		logic             sclk_q;
		logic [2:0]       edge_cnt;
		logic             over;
		logic [7:0]       shift_in;
		logic [7:0]       shift_out;
		logic             miso;
		logic             miso_en;
		logic             ovsd_en;
		logic             c2;
		logic [1:0]       mode;
		logic             wdclr;
		logic [3:0]       lin_ctl;
		logic [3:0]       interrupt_mask;
		logic [3:0]       interrupt_source;
		logic             pwr_loss;
		logic             txd_stuck;
		logic             rx_short;
		logic             lin_ot;
		logic [31:0]      txd_cnt;
		logic [31:0]      wk_cnt;
		sbc_wake_e        wk;
		logic             wake_rst;
		logic [23:0]      snap;
		logic             auto_rx;
	} sbc_regs_s;

	sbc_regs_s  st_ff;
	sbc_regs_s  nxt_st;
	logic [2:0] pins_s;
	logic       cs_s;
	logic       sclk_s;
	logic       mosi_s;
	logic       txd_s;
	logic       lin_s;
	logic [3:0] lin_sts;
	logic [3:0] summary;
	logic [3:0] rd_data;
	logic       cs_fall;
	logic       cs_rise;
	logic       sclk_fall;
	logic       sclk_rise;
	logic       valid;
	logic       soft_rst;
	logic       lin_err;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	sbc_sync #(.WIDTH(3), .INIT(4'h7)) u_sync_spi (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in ({cs_n, sclk, mosi}),
		.sync_out (pins_s)
	);
	sbc_sync #(.WIDTH(2), .INIT(4'h3)) u_sync_lin (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in ({txd, lin_rx}),
		.sync_out ({txd_s, lin_s})
	);
	assign cs_s   = pins_s[2];
	assign sclk_s = pins_s[1];
	assign mosi_s = pins_s[0];

	// edge detection on synchronised pins
	assign cs_fall   = st_ff.cs_q & ~cs_s;
	assign cs_rise   = ~st_ff.cs_q & cs_s;
	assign sclk_fall = ~cs_s & st_ff.sclk_q & ~sclk_s;
	assign sclk_rise = ~cs_s & ~st_ff.sclk_q & sclk_s;
	assign valid     = cs_rise & (st_ff.edge_cnt == 3'h0) & st_ff.over;

	// summary nibble and status read mux
	assign lin_sts = {st_ff.rx_short, st_ff.txd_stuck, st_ff.lin_ot, 1'b0};
	assign summary = {|{vmon_status[3:1], st_ff.pwr_loss},
	                  |lin_sts,
	                  |hs_status,
	                  |ls_status};

	// address pairs 0 to 5 pick status from the snapshot taken at frame start; pair 7 reads the interrupt source
	always_comb begin
		rd_data = 4'h0;
		if (st_ff.shift_in[3:1] == 3'h0) begin
			rd_data = st_ff.snap[23:20];
		end else if (st_ff.shift_in[3:1] == 3'h1) begin
			rd_data = st_ff.snap[19:16];
		end else if (st_ff.shift_in[3:1] == 3'h2) begin
			rd_data = st_ff.snap[15:12];
		end else if (st_ff.shift_in[3:1] == 3'h3) begin
			rd_data = st_ff.snap[11:8];
		end else if (st_ff.shift_in[3:1] == 3'h4) begin
			rd_data = st_ff.snap[7:4];
		end else if (st_ff.shift_in[3:1] == 3'h5) begin
			rd_data = st_ff.snap[3:0];
		end else if (st_ff.shift_in[3:1] == 3'h7) begin
			rd_data = st_ff.interrupt_source;
		end
	end

	assign soft_rst = reset_mode | pin_reset;
	assign lin_err  = (st_ff.txd_stuck & ~txd_s) | rxd_short | lin_overtemp;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.cs_q   = cs_s;
		nxt_st.sclk_q = sclk_s;
		nxt_st.wdclr  = 1'b0;

		// frame start: drive MISO, load summary, freeze the six status pairs
		if (cs_fall) begin
			nxt_st.snap      = {vmon_status[3:1], st_ff.pwr_loss, wake_status, lin_sts, hs_status, ls_status, wd_status};
			nxt_st.miso_en   = 1'b1;
			nxt_st.edge_cnt  = 3'h0;
			nxt_st.over      = 1'b0;
			nxt_st.shift_out = {summary, 4'h0};
			nxt_st.miso      = summary[3];
		end
		// sample on falling SCLK
		if (sclk_fall) begin
			nxt_st.shift_in = {st_ff.shift_in[6:0], mosi_s};
			nxt_st.edge_cnt = st_ff.edge_cnt + 3'h1;
			if (st_ff.over) begin
				nxt_st.edge_cnt = 3'h1; // any edge past eight keeps the frame invalid
			end else if (st_ff.edge_cnt == 3'h7) begin
				nxt_st.over = 1'b1;
			end
		end
		// drive on rising SCLK
		if (sclk_rise) begin
			if (st_ff.edge_cnt == 3'h4) begin
				nxt_st.miso = rd_data[3];
				nxt_st.shift_out = {rd_data, 4'h0};
			end else begin
				nxt_st.miso = st_ff.shift_out[6];
				nxt_st.shift_out = {st_ff.shift_out[6:0], 1'b0};
			end
		end
		// frame end: release MISO and commit valid writes
		if (cs_rise) begin
			nxt_st.miso_en = 1'b0;
			if (valid) begin
				if (st_ff.shift_in[7:4] == `SBC_ADR_MODE) begin
					nxt_st.ovsd_en = st_ff.shift_in[`SBC_MODE_OVSD_BIT];
					nxt_st.c2      = st_ff.shift_in[2];
					nxt_st.mode    = st_ff.shift_in[1:0];
					nxt_st.wdclr   = (st_ff.shift_in[1:0] == 2'h3);
				end else if (st_ff.shift_in[7:4] == `SBC_ADR_LIN_CTL) begin
					nxt_st.lin_ctl = st_ff.shift_in[3:0];
					nxt_st.auto_rx = 1'b0;
				end else if (st_ff.shift_in[7:4] == `SBC_ADR_IRQ_MASK) begin
					nxt_st.interrupt_mask = st_ff.shift_in[3:0];
				end
				if (st_ff.shift_in[7:5] == 3'h0) begin
					nxt_st.pwr_loss = 1'b0;
				end
				if (st_ff.shift_in[7:5] == 3'h2) begin
					if (txd_s) begin
						nxt_st.txd_stuck = 1'b0;
					end
					if (!rxd_short) begin
						nxt_st.rx_short = 1'b0;
					end
					if (!lin_overtemp) begin
						nxt_st.lin_ot = 1'b0;
					end
				end
				if (st_ff.shift_in[7:4] == `SBC_ADR_IRQ_SRC || st_ff.shift_in[7:4] == `SBC_ADR_IRQ_MASK) begin
					nxt_st.interrupt_source = 4'h0;
				end
			end
		end

		// TXD stuck dominant timer
		if (txd_s) begin
			nxt_st.txd_cnt = 32'h0;
		end else if (st_ff.txd_cnt < TXD_STUCK_CYC) begin
			nxt_st.txd_cnt = st_ff.txd_cnt + 32'h1;
		end else begin
			nxt_st.txd_stuck = 1'b1;
		end
		// fault set wins over the read clear
		if (rxd_short) begin
			nxt_st.rx_short = 1'b1;
		end
		if (lin_overtemp) begin
			nxt_st.lin_ot = 1'b1;
		end
		if (lin_err) begin
			nxt_st.lin_ctl[`SBC_LIN_RECEIVE_ONLY_BIT_BIT] = 1'b1;
			nxt_st.auto_rx = 1'b1;
			nxt_st.interrupt_source = `SBC_ISR_LIN_FAULT;
		end else if (nxt_st.auto_rx) begin
			// fault gone: drop the receive-only bit that the fault set
			nxt_st.lin_ctl[`SBC_LIN_RECEIVE_ONLY_BIT_BIT] = 1'b0;
			nxt_st.auto_rx = 1'b0;
		end

		// LIN wake filter in stop and sleep
		nxt_st.wake_rst = 1'b0;
		case (st_ff.wk)
			SBC_WK_IDLE: begin
				nxt_st.wk_cnt = 32'h0;
				if (!lin_s && (st_ff.mode == 2'h2 ||
				    (st_ff.mode == 2'h1 && !st_ff.lin_ctl[`SBC_LIN_RECEIVE_ONLY_BIT_BIT]))) begin
					nxt_st.wk = SBC_WK_DOM;
				end
			end
			SBC_WK_DOM: begin
				if (lin_s) begin
					nxt_st.wk = SBC_WK_IDLE;
				end else if (st_ff.wk_cnt >= WAKE_FILT_CYC) begin
					nxt_st.wk = SBC_WK_ARMED;
				end else begin
					nxt_st.wk_cnt = st_ff.wk_cnt + 32'h1;
				end
			end
			SBC_WK_ARMED: begin
				if (lin_s) begin
					nxt_st.wk = SBC_WK_IDLE;
					nxt_st.interrupt_source = `SBC_ISR_LIN_WAKE;
					nxt_st.wake_rst = (st_ff.mode == 2'h2);
				end
			end
			default: begin
				nxt_st.wk = SBC_WK_IDLE;
			end
		endcase

		// reset mode and pin reset restore their bits
		if (soft_rst) begin
			nxt_st.lin_ctl[`SBC_LIN_RECEIVE_ONLY_BIT_BIT] = 1'b0;
			nxt_st.interrupt_mask = `SBC_IMR_RST;
		end
		if (por_pulse) begin
			nxt_st.pwr_loss = 1'b1;
			nxt_st.ovsd_en  = 1'b1;
			nxt_st.c2       = 1'b0;
			nxt_st.lin_ctl  = `SBC_LIN_CTL_RST;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_ff          <= '0;
			st_ff.cs_q     <= 1'b1;
			st_ff.sclk_q   <= 1'b1;
			st_ff.ovsd_en  <= 1'b1;
			st_ff.pwr_loss <= 1'b1;
			st_ff.wk       <= SBC_WK_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign miso_o          = st_ff.miso;
	assign miso_oe         = st_ff.miso_en;
	assign lin_tx_enable   = ~st_ff.lin_ctl[`SBC_LIN_RECEIVE_ONLY_BIT_BIT] & ~(st_ff.txd_stuck & ~txd_s) &
	                         (st_ff.mode != 2'h1) & (st_ff.mode != 2'h2);
	assign rxd_follow_bus  = st_ff.lin_ctl[`SBC_LIN_RECEIVE_ONLY_BIT_BIT];
	assign irq_n           = ~(st_ff.interrupt_mask[`SBC_IMR_LIN_BIT] & |lin_sts);
	assign side_drivers_off = st_ff.ovsd_en & vmon_status[3];
	assign op_mode         = st_ff.mode;
	assign watchdog_clear  = st_ff.wdclr;
	assign wake_reset_req  = st_ff.wake_rst;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	AST_STUCK_IRQ: assert property (@(posedge clk_sys) disable iff (rst || soft_rst || por_pulse)
		!txd_s && (st_ff.txd_cnt >= TXD_STUCK_CYC) && st_ff.interrupt_mask[`SBC_IMR_LIN_BIT] && !cs_rise |=> !irq_n)
		else $error("stuck fault without irq");
	AST_STUCK_TXOFF: assert property (@(posedge clk_sys) disable iff (rst)
		st_ff.txd_stuck && !txd_s |-> !lin_tx_enable) else $error("transmitter on while stuck");
	AST_RECEIVE_ONLY_BIT: assert property (@(posedge clk_sys) disable iff (rst)
		st_ff.lin_ctl[`SBC_LIN_RECEIVE_ONLY_BIT_BIT] |-> !lin_tx_enable) else $error("tx on in receive only");
	AST_ERR_RECEIVE_ONLY_BIT: assert property (@(posedge clk_sys) disable iff (rst)
		lin_err && !soft_rst && !por_pulse |=> st_ff.lin_ctl[`SBC_LIN_RECEIVE_ONLY_BIT_BIT]) else $error("receive_only_bit not set");
	AST_MISO_HIZ: assert property (@(posedge clk_sys) disable iff (rst)
		cs_rise |=> !miso_oe) else $error("miso driven after deselect");
	AST_MISO_ON: assert property (@(posedge clk_sys) disable iff (rst)
		cs_fall |=> miso_oe) else $error("miso not enabled");
	AST_OVSD: assert property (@(posedge clk_sys) disable iff (rst || por_pulse)
		valid && (st_ff.shift_in[7:4] == `SBC_ADR_MODE) |=>
		side_drivers_off == (st_ff.shift_in[`SBC_MODE_OVSD_BIT] && vmon_status[3])) else $error("shutdown mismatch");
	AST_BAD_FRAME: assert property (@(posedge clk_sys) disable iff (rst || por_pulse || soft_rst)
		cs_rise && !valid |=> $stable(st_ff.interrupt_mask) && $stable(st_ff.mode)) else $error("bad frame wrote");
	AST_SUMMARY: assert property (@(posedge clk_sys) disable iff (rst)
		cs_fall |=> st_ff.shift_out[6] == ($past(st_ff.rx_short) || $past(st_ff.txd_stuck) || $past(st_ff.lin_ot)))
		else $error("lin summary wrong");
endmodule : sbc_spi_regs
`default_nettype wire

// ==== sbc_host_model.sv ====
/*
 * sbc_host_model.sv - host side serial master for the register interface.
 * assumes: clk_sys paces the pins; sclk half period is four system clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module sbc_host_model (
	// clock
	input  wire logic clk_sys,
	// serial pins
	input  wire logic miso,
	output var  logic cs_n,
	output var  logic sclk,
	output var  logic mosi
);
	// ---------------------------------------------------------------
	// pin drive
	// ---------------------------------------------------------------
	// pins idle deselected with sclk high
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		mosi = 1'b0;
	end

	// wait a number of system clocks
	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : hold

	// one frame, msb first, with a chosen count of sampling edges
	task automatic xfer(input logic [7:0] tx, input int nedge, output logic [7:0] rx);
		rx = 8'h00;
		@(posedge clk_sys);
		cs_n <= 1'b0;
		mosi <= tx[7];
		for (int i = 0; i < nedge; i++) begin
			hold(4);
			rx = {rx[6:0], miso};
			sclk <= 1'b0;
			hold(4);
			sclk <= 1'b1;
			if (i < 7)
				mosi <= tx[6 - i];
		end
		hold(4);
		cs_n <= 1'b1;
		mosi <= ~mosi; // released line shows no stale bit
		hold(8);
	endtask : xfer
endmodule : sbc_host_model
`default_nettype wire

// ==== sbc_spi_regs_bench.sv ====
/*
 * sbc_spi_regs_bench.sv - self-checking bench for the serial register block.
 * assumes: host model drives the serial pins; short stuck and filter counts.
 */
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_regs_bench
	import sbc_pkg::*;
;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic       clk_sys, rst, por_pulse, reset_mode, pin_reset;
	logic       cs_n, sclk, mosi, miso_o, miso_oe;
	logic       txd, lin_rx, lin_overtemp, rxd_short, lin_tx_enable, rxd_follow_bus;
	logic [3:0] vmon_status, wake_status, hs_status, ls_status, wd_status;
	logic       irq_n, side_drivers_off, watchdog_clear, wake_reset_req;
	logic [1:0] op_mode;
	logic [7:0] rx;
	logic       wd_seen, wr_seen;
	int         errors, samples_checked;
	wire logic  miso;

	// miso wire resolved from the output enable
	assign miso = miso_oe ? miso_o : 1'bz;

	sbc_spi_regs #(.TXD_STUCK_CYC(200), .WAKE_FILT_CYC(20)) sbc_spi_regs_inst (.clk_sys, .rst,
		.por_pulse, .reset_mode, .pin_reset, .cs_n, .sclk, .mosi, .miso_o, .miso_oe, .txd,
		.lin_rx, .lin_overtemp, .rxd_short, .lin_tx_enable, .rxd_follow_bus, .vmon_status,
		.wake_status, .hs_status, .ls_status, .wd_status, .irq_n, .side_drivers_off,
		.op_mode, .watchdog_clear, .wake_reset_req);

	sbc_host_model sbc_host_model_inst (.clk_sys, .miso, .cs_n, .sclk, .mosi);

	// clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// remember one-cycle pulses
	initial begin
		wd_seen = 1'b0;
		wr_seen = 1'b0;
	end
	always @(posedge clk_sys) begin
		if (watchdog_clear === 1'b1)
			wd_seen <= 1'b1;
		if (wake_reset_req === 1'b1)
			wr_seen <= 1'b1;
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// full frame and compare of the returned byte
	task automatic rd(input logic [7:0] tx, input logic [7:0] exp);
		sbc_host_model_inst.xfer(tx, 8, rx);
		chk(rx, exp);
	endtask : rd

	// dominant bus pulse then release
	task automatic bus_pulse;
		lin_rx <= 1'b0;
		repeat (40) @(posedge clk_sys);
		lin_rx <= 1'b1;
		repeat (10) @(posedge clk_sys);
	endtask : bus_pulse

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	// power-on flag seen then cleared by the voltage read
	task automatic t_power;
		por_pulse <= 1'b1;
		@(posedge clk_sys);
		por_pulse <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd(8'h10, 8'h81);
		chk(8'(miso_oe), 8'h00);
		rd(8'h10, 8'h00);
		$display("test power done");
	endtask : t_power

	// summary nibble and paired status reads
	task automatic t_summary;
		hs_status <= 4'h2;
		ls_status <= 4'h8;
		wake_status <= 4'h3;
		rd(8'h90, 8'h38);
		rd(8'h70, 8'h32);
		rd(8'h30, 8'h33);
		hs_status <= 4'h0;
		ls_status <= 4'h0;
		wake_status <= 4'h0;
		$display("test summary done");
	endtask : t_summary

	// mode decode, shutdown enable and short or long frames
	task automatic t_mode;
		vmon_status <= 4'h8;
		repeat (3) @(posedge clk_sys);
		chk(8'(side_drivers_off), 8'h01);
		rd(8'h00, 8'h88);
		chk(8'(side_drivers_off), 8'h00);
		for (int m = 0; m < 4; m++) begin
			rd({6'h02, m[1:0]}, 8'h88);
			chk(8'(op_mode), 8'(m));
		end
		chk(8'(wd_seen), 8'h01);
		sbc_host_model_inst.xfer(8'h0A, 7, rx);
		chk(8'(op_mode), 8'h03);
		sbc_host_model_inst.xfer(8'h0A, 9, rx);
		chk(8'(op_mode), 8'h03);
		rd(8'h08, 8'h88);
		chk(8'(side_drivers_off), 8'h01);
		vmon_status <= 4'h0;
		$display("test mode done");
	endtask : t_mode

	// stuck transmit data detection, interrupt and read clear
	task automatic t_txd;
		rd(8'hE2, 8'h00);
		txd <= 1'b0;
		repeat (210) @(posedge clk_sys);
		chk(8'(lin_tx_enable), 8'h00);
		chk(8'(irq_n), 8'h00);
		chk(8'(rxd_follow_bus), 8'h01);
		rd(8'h50, 8'h44);
		rd(8'h50, 8'h44);
		txd <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk(8'(lin_tx_enable), 8'h01);
		rd(8'h50, 8'h44);
		rd(8'h50, 8'h00);
		chk(8'(irq_n), 8'h01);
		rd(8'hF0, 8'h02);
		$display("test txd done");
	endtask : t_txd

	// receive only control and pin reset
	task automatic t_receive_only_bit;
		rd(8'h44, 8'h00);
		chk(8'(lin_tx_enable), 8'h00);
		chk(8'(rxd_follow_bus), 8'h01);
		pin_reset <= 1'b1;
		@(posedge clk_sys);
		pin_reset <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(8'(rxd_follow_bus), 8'h00);
		chk(8'(lin_tx_enable), 8'h01);
		$display("test receive_only_bit done");
	endtask : t_receive_only_bit

	// bus wake in stop and sleep modes
	task automatic t_wake;
		int n;
		rd(8'h44, 8'h00);
		rd(8'h09, 8'h00);
		bus_pulse;
		rd(8'hF0, 8'h00);
		chk(8'(rxd_follow_bus), 8'h01);
		rd(8'h40, 8'h00);
		chk(8'(lin_tx_enable), 8'h00);
		bus_pulse;
		rd(8'hF0, 8'h01);
		chk(8'(wr_seen), 8'h00);
		rd(8'h0A, 8'h00);
		chk(8'(lin_tx_enable), 8'h00);
		bus_pulse;
		n = 0;
		while (wr_seen !== 1'b1 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk(8'(wr_seen), 8'h01);
		rd(8'hF0, 8'h01);
		rd(8'h08, 8'h00);
		$display("test wake done");
	endtask : t_wake

	// ---------------------------------------------------------------
	// main sequence and hang guard
	// ---------------------------------------------------------------
	initial begin
		{errors, samples_checked} = '0;
		{rst, por_pulse, reset_mode, pin_reset, txd, lin_rx} = 6'h23;
		{lin_overtemp, rxd_short, vmon_status, wake_status} = '0;
		{hs_status, ls_status, wd_status} = '0;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		t_power;
		t_summary;
		t_mode;
		t_txd;
		t_receive_only_bit;
		t_wake;
		end_sim;
	end

	initial begin
		repeat (60000) @(posedge clk_sys);
		errors++;
		end_sim;
	end
endmodule : sbc_spi_regs_bench
`default_nettype wire
